// File: src/decoder_pkg.sv
// constants and types shared by the instruction word decoder
package decoder_pkg;

  // ==========================================================
  // word layout
  localparam int WORD_W      = 14;
  localparam int CLASS_HI    = 13;
  localparam int CLASS_LO    = 12;
  localparam int FILE_W      = 7;
  localparam int FILE_LSB    = 0;
  localparam int DEST_BIT    = 7;
  localparam int BITPOS_W    = 3;
  localparam int BITPOS_LSB  = 7;
  localparam int LIT8_W      = 8;
  localparam int LIT11_W     = 11;
  localparam int DATA_W      = 8;

  // ==========================================================
  // class codes in the top two bits
  localparam logic [1:0] CODE_BYTE = 2'h0;
  localparam logic [1:0] CODE_BIT  = 2'h1;
  localparam logic [1:0] CODE_WIDE = 2'h2;

  typedef enum logic [1:0] {
    CL_BYTE,
    CL_BIT,
    CL_CTRL
  } iclass_e;

  // ==========================================================
  // special words, compared under a care mask
  localparam logic [WORD_W-1:0] SLEEP_WORD = 14'h0063;
  localparam logic [WORD_W-1:0] KICK_WORD  = 14'h0064;
  localparam logic [WORD_W-1:0] CARE_ALL   = 14'h3fff;

  // ==========================================================
  // instruction cycle timing
  localparam int         OSC_PER_CYCLE = 4;
  localparam logic [1:0] LAST_PHASE    = 2'(OSC_PER_CYCLE - 1);
  localparam logic [1:0] WRITE_PHASE   = 2'h2;

  // ==========================================================
  // status flag positions and reset values
  localparam int   STAT_PD_BIT = 3;
  localparam int   STAT_TO_BIT = 4;
  localparam logic RST_PD      = 1'b1;
  localparam logic RST_TO      = 1'b1;

endpackage

// File: src/quad_phase_gen.sv
// four-phase instruction cycle generator
`timescale 1ns/10ps
`default_nettype none
module quad_phase_gen
  import decoder_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  output logic      [1:0] phase_out,
  output logic            start_out
);

  // ==========================================================
  // phase counter, one oscillator period per clock
  logic [1:0] phase_d;
  logic       start_d;

  always_comb begin
    phase_d = (phase_out == LAST_PHASE) ? 2'h0 : phase_out + 2'h1;
    start_d = (phase_out == LAST_PHASE);
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_out <= 2'h0;
      start_out <= 1'b1;
    end else begin
      phase_out <= phase_d;
      start_out <= start_d;
    end
  end

endmodule
`default_nettype wire

// File: src/word_field_split.sv
// splits a fetched word into class and operand fields
`timescale 1ns/10ps
`default_nettype none
module word_field_split
  import decoder_pkg::*;
(
  input  wire logic [WORD_W-1:0]  word_in,
  output iclass_e                 class_out,
  output logic      [FILE_W-1:0]  file_addr_out,
  output logic                    dest_file_out,
  output logic      [BITPOS_W-1:0] bit_pos_out,
  output logic      [LIT11_W-1:0] lit_out,
  output logic                    lit_wide_out,
  output logic                    is_sleep_out,
  output logic                    is_kick_out
);

  // ==========================================================
  // masked compare, so loose bits never change the result
  function automatic logic match_word(input logic [WORD_W-1:0] w,
                                      input logic [WORD_W-1:0] pat,
                                      input logic [WORD_W-1:0] care);
    match_word = ((w ^ pat) & care) == '0;
  endfunction

  always_comb begin
    is_sleep_out  = match_word(word_in, SLEEP_WORD, CARE_ALL); // RL8
    is_kick_out   = match_word(word_in, KICK_WORD, CARE_ALL); // RL8
    file_addr_out = word_in[FILE_LSB +: FILE_W]; // RL3
    dest_file_out = word_in[DEST_BIT];
    bit_pos_out   = word_in[BITPOS_LSB +: BITPOS_W]; // RL6
    lit_wide_out  = 1'b0;
    lit_out       = {{(LIT11_W-LIT8_W){1'b0}}, word_in[LIT8_W-1:0]}; // RL7 RL8
    // control words live in the byte space but must not write back
    if (is_sleep_out || is_kick_out) begin
      class_out = CL_CTRL;
    end else if (word_in[CLASS_HI:CLASS_LO] == CODE_BYTE) begin
      class_out = CL_BYTE; // RL2
    end else if (word_in[CLASS_HI:CLASS_LO] == CODE_BIT) begin
      class_out = CL_BIT; // RL2
    end else begin
      class_out = CL_CTRL; // RL2
      if (word_in[CLASS_HI:CLASS_LO] == CODE_WIDE) begin
        lit_wide_out = 1'b1;
        lit_out      = word_in[LIT11_W-1:0]; // RL7
      end
    end
  end

endmodule
`default_nettype wire

// File: src/instruction_word_decoder.sv
// instruction word decoder and cycle sequencer
//
// Summary of operation
// [RL1] each 14-bit word splits into an opcode part and operand fields
// [RL2] every word is sorted as byte, bit, or literal and control class
// [RL3] byte and bit words carry a 7-bit file address, 0x00 to 0x7F
// [RL4] byte word with destination 0 writes the accumulator only
// [RL5] byte word with destination 1 writes back the addressed file register
// [RL6] bit words select one bit of the 8-bit file register by position
// [RL7] literal words yield an 8-bit or 11-bit constant
// [RL8] don't-care bits never change decoding
// [RL9] a word completes in one instruction cycle unless it branches
// [RL10] a branch or taken skip adds a second cycle executed as no-op
// [RL11] an instruction cycle is four oscillator periods
// [RL12] power-down clears watchdog, clears power-down flag, sets time-out flag
// [RL13] watchdog kick and power-down both clear watchdog and its prescaler
// [RL14] class and fields reach the datapath in the word's own cycle
`timescale 1ns/10ps
`default_nettype none
module instruction_word_decoder
  import decoder_pkg::*;
(
  input  wire logic                          core_clk_in,
  input  wire logic                          resetn_in,
  input  wire logic [decoder_pkg::WORD_W-1:0] instr_word_in,
  input  wire logic                          instr_valid_in,
  input  wire logic                          branch_taken_in,
  input  wire logic                          guard_timeout_in,
  output logic                               fetch_ack_out,
  output logic      [1:0]                    phase_out,
  output logic                               cycle_start_out,
  output logic                               nop_cycle_out,
  output decoder_pkg::iclass_e               class_out,
  output logic      [decoder_pkg::FILE_W-1:0] file_addr_out,
  output logic                               dest_file_out,
  output logic      [decoder_pkg::BITPOS_W-1:0] bit_pos_out,
  output logic      [decoder_pkg::DATA_W-1:0] bit_sel_out,
  output logic      [decoder_pkg::LIT11_W-1:0] lit_out,
  output logic                               lit_wide_out,
  output logic                               acc_we_out,
  output logic                               file_we_out,
  output logic                               guard_clear_out,
  output logic      [decoder_pkg::DATA_W-1:0] status_flags_out
);
  import decoder_pkg::*;

  // ==========================================================
  // reset release through two flops
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ==========================================================
  // watchdog time-out comes from its own oscillator
  logic tmo_meta_q;
  logic tmo_sync_q;
  logic tmo_last_q;
  logic tmo_rise;

  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tmo_meta_q <= 1'b0;
      tmo_sync_q <= 1'b0;
      tmo_last_q <= 1'b0;
    end else begin
      tmo_meta_q <= guard_timeout_in;
      tmo_sync_q <= tmo_meta_q;
      tmo_last_q <= tmo_sync_q;
    end
  end

  assign tmo_rise = tmo_sync_q && !tmo_last_q;

  // ==========================================================
  // phase generator and field split
  logic [1:0] phase;
  logic       start;

  quad_phase_gen u_phase (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_q),
    .phase_out   (phase),
    .start_out   (start)
  );

  iclass_e              dec_class;
  logic [FILE_W-1:0]    dec_file;
  logic                 dec_dest;
  logic [BITPOS_W-1:0]  dec_pos;
  logic [LIT11_W-1:0]   dec_lit;
  logic                 dec_wide;
  logic                 dec_sleep;
  logic                 dec_kick;

  word_field_split u_split (
    .word_in       (instr_word_in),
    .class_out     (dec_class),
    .file_addr_out (dec_file),
    .dest_file_out (dec_dest),
    .bit_pos_out   (dec_pos),
    .lit_out       (dec_lit),
    .lit_wide_out  (dec_wide),
    .is_sleep_out  (dec_sleep),
    .is_kick_out   (dec_kick)
  ); // RL1

  // one-hot bit select, one decoder cell per bit
  logic [DATA_W-1:0] sel_onehot;

  for (genvar i = 0; i < DATA_W; i++) begin : g_sel
    assign sel_onehot[i] = (dec_pos == BITPOS_W'(i)); // RL6
  end

  // ==========================================================
  // cycle sequencer
  typedef enum logic [1:0] {
    ST_EXEC,
    ST_FLUSH,
    ST_STALL
  } cycle_state_e;

  cycle_state_e state_q;
  cycle_state_e state_d;
  logic         branch_pend_q;
  logic         branch_pend_d;
  logic         take;

  // the word on the fetch port is dropped in a flush cycle: it was prefetched
  assign take = start && instr_valid_in && !branch_pend_q;

  always_comb begin
    state_d       = state_q;
    branch_pend_d = branch_pend_q;
    if (start) begin
      if (branch_pend_q) begin
        state_d = ST_FLUSH; // RL10
      end else if (instr_valid_in) begin
        state_d = ST_EXEC; // RL9
      end else begin
        state_d = ST_STALL;
      end
      branch_pend_d = take && dec_wide; // RL10
    end else begin
      case (state_q)
        ST_EXEC: branch_pend_d = branch_pend_q || branch_taken_in; // RL10
        default: branch_pend_d = branch_pend_q;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q       <= ST_STALL;
      branch_pend_q <= 1'b0;
    end else begin
      state_q       <= state_d;
      branch_pend_q <= branch_pend_d;
    end
  end

  // ==========================================================
  // decoded fields, loaded at the cycle's first edge
  logic is_sleep_q;
  logic is_kick_q;

  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      class_out     <= CL_CTRL;
      file_addr_out <= '0;
      dest_file_out <= 1'b0;
      bit_pos_out   <= '0;
      bit_sel_out   <= '0;
      lit_out       <= '0;
      lit_wide_out  <= 1'b0;
      is_sleep_q    <= 1'b0;
      is_kick_q     <= 1'b0;
    end else if (take) begin
      class_out     <= dec_class; // RL14
      file_addr_out <= dec_file; // RL3
      dest_file_out <= dec_dest;
      bit_pos_out   <= dec_pos;
      bit_sel_out   <= sel_onehot; // RL6
      lit_out       <= dec_lit; // RL7
      lit_wide_out  <= dec_wide;
      is_sleep_q    <= dec_sleep;
      is_kick_q     <= dec_kick;
    end
  end

  // ==========================================================
  // strobes, landing in the last oscillator period
  logic exec_valid_q;
  logic exec_valid_d;
  logic acc_we_d;
  logic file_we_d;
  logic clear_d;
  logic pd_d;
  logic to_d;
  logic pd_q;
  logic to_q;

  always_comb begin
    exec_valid_d = start ? take : exec_valid_q;
    acc_we_d     = 1'b0;
    file_we_d    = 1'b0;
    clear_d      = 1'b0;
    pd_d         = pd_q;
    to_d         = to_q;
    if (exec_valid_q && phase == WRITE_PHASE) begin
      acc_we_d  = (class_out == CL_BYTE) && !dest_file_out; // RL4
      file_we_d = (class_out == CL_BYTE) && dest_file_out; // RL5
      clear_d   = is_sleep_q || is_kick_q; // RL13
      if (is_sleep_q) begin
        pd_d = 1'b0; // RL12
        to_d = 1'b1; // RL12
      end
    end
    // a time-out in the same cycle still gets recorded
    if (tmo_rise) begin
      to_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      exec_valid_q    <= 1'b0;
      acc_we_out      <= 1'b0;
      file_we_out     <= 1'b0;
      guard_clear_out <= 1'b0;
      pd_q            <= RST_PD;
      to_q            <= RST_TO;
    end else begin
      exec_valid_q    <= exec_valid_d;
      acc_we_out      <= acc_we_d;
      file_we_out     <= file_we_d;
      guard_clear_out <= clear_d;
      pd_q            <= pd_d;
      to_q            <= to_d;
    end
  end

  // ==========================================================
  // registered copies of timing and status
  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fetch_ack_out    <= 1'b0;
      phase_out        <= 2'h0;
      cycle_start_out  <= 1'b0;
      nop_cycle_out    <= 1'b1;
      status_flags_out <= '0;
    end else begin
      fetch_ack_out    <= take;
      phase_out        <= phase; // RL11
      cycle_start_out  <= start;
      nop_cycle_out    <= exec_valid_d ? 1'b0 : 1'b1; // RL9
      status_flags_out <= '0;
      status_flags_out[STAT_PD_BIT] <= pd_q;
      status_flags_out[STAT_TO_BIT] <= to_q;
    end
  end

  // ==========================================================
  // checks
  // checks arm one clock after release: the release edge still shows reset values
  logic chk_arm_q;

  always_ff @(posedge core_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      chk_arm_q <= 1'b0;
    end else begin
      chk_arm_q <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!chk_arm_q);

  chk_class_sort: assert property ( // RL2
    take && instr_word_in[CLASS_HI:CLASS_LO] == CODE_BIT |=> class_out == CL_BIT)
    else $error("bit class word not sorted as bit class");

  chk_field_latch: assert property ( // RL3
    take |=> file_addr_out == $past(instr_word_in[FILE_W-1:0]))
    else $error("file address not taken from the word");

  chk_acc_only: assert property ( // RL4
    acc_we_out |-> !file_we_out && class_out == CL_BYTE && !dest_file_out)
    else $error("accumulator write with wrong destination");

  chk_file_write: assert property ( // RL5
    take && dec_class == CL_BYTE && dec_dest |-> ##3 file_we_out)
    else $error("file write missing in last period");

  chk_bit_select: assert property ( // RL6
    exec_valid_q && class_out == CL_BIT |-> bit_sel_out == (8'h01 << bit_pos_out))
    else $error("bit select does not match position");

  chk_lit_narrow: assert property ( // RL7
    exec_valid_q && !lit_wide_out |-> lit_out[LIT11_W-1:LIT8_W] == '0)
    else $error("narrow literal has upper bits set");

  chk_single_cycle: assert property ( // RL9
    start && !branch_pend_q && instr_valid_in |=> !nop_cycle_out [*4])
    else $error("plain word did not run a full cycle");

  chk_flush_one: assert property ( // RL10
    start && branch_pend_q |=> nop_cycle_out [*4] ##1 (nop_cycle_out == !$past(take)))
    else $error("branch not followed by exactly one no-op cycle");

  chk_cycle_four: assert property ( // RL11
    start |=> !start [*3] ##1 start)
    else $error("instruction cycle is not four periods");

  chk_sleep_flags: assert property ( // RL12
    take && dec_sleep |-> ##3 guard_clear_out ##2 !status_flags_out[STAT_PD_BIT])
    else $error("power-down did not clear watchdog and flag");

  chk_kick_clear: assert property ( // RL13
    take && dec_kick |-> ##3 guard_clear_out ##1 !guard_clear_out)
    else $error("watchdog kick not a single pulse");

  cov_byte_write: cover property (take && dec_class == CL_BYTE && dec_dest ##3 file_we_out);
  cov_bit_op: cover property (take && dec_class == CL_BIT);
  cov_branch: cover property (take && dec_wide ##5 nop_cycle_out);
  cov_sleep: cover property (take && dec_sleep ##3 guard_clear_out);

endmodule
`default_nettype wire

// File: test/fetch_partner.sv
// program memory and branch source facing the decoder fetch port
`timescale 1ns/10ps
`default_nettype none
module fetch_partner (
  input  wire logic        clk_in,
  input  wire logic        clear_in,
  input  wire logic        go_in,
  input  wire logic        load_en_in,
  input  wire logic [14:0] load_val_in,
  input  wire logic        fetch_ack_in,
  output logic      [13:0] word_out,
  output logic             valid_out,
  output logic             branch_out
);
  // ==========================================================
  // storage: bit 14 asks for a taken branch on that word
  logic [14:0] mem_q [16];
  logic [4:0]  pc_q   = 5'h00;
  logic [4:0]  cnt_q  = 5'h00;
  logic [13:0] last_q = 14'h0000;

  // ==========================================================
  // idle word is the inverse of the last one, never a stale copy
  assign valid_out = go_in && (pc_q < cnt_q);
  assign word_out  = valid_out ? mem_q[pc_q[3:0]][13:0] : ~last_q;

  always @(posedge clk_in) begin
    branch_out <= 1'b0;
    if (clear_in) begin
      pc_q  <= 5'h00;
      cnt_q <= 5'h00;
    end else if (load_en_in) begin
      mem_q[cnt_q[3:0]] <= load_val_in;
      cnt_q             <= cnt_q + 5'h01;
    end else if (fetch_ack_in) begin
      // pc moves only on an ack, so a dropped word is offered again
      last_q     <= mem_q[pc_q[3:0]][13:0];
      branch_out <= mem_q[pc_q[3:0]][14];
      pc_q       <= pc_q + 5'h01;
    end
  end
endmodule
`default_nettype wire

// File: test/test_instruction_word_decoder.sv
// self-checking bench for the instruction word decoder
`timescale 1ns/10ps
`default_nettype none
module test_instruction_word_decoder;
  import decoder_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic        clk = 1'b0, rst_n = 1'b0, guard_to = 1'b0;
  logic        clear = 1'b0, go = 1'b0, load_en = 1'b0;
  logic [14:0] load_val = 15'h0000;
  logic [13:0] word;
  logic        valid, branch, fetch_ack, nop, dest, lwide, acc_we, file_we, gclr, cst;
  logic [1:0]  ph;
  iclass_e     cls;
  logic [6:0]  faddr;
  logic [2:0]  bpos;
  logic [7:0]  bsel, stat;
  logic [10:0] lit;
  int          failures = 0, check_count = 0, cyc = 0;
  logic [14:0] prog_q[$];

  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  fetch_partner model (.clk_in(clk), .clear_in(clear), .go_in(go), .load_en_in(load_en),
    .load_val_in(load_val), .fetch_ack_in(fetch_ack), .word_out(word), .valid_out(valid),
    .branch_out(branch));

  instruction_word_decoder dut (.core_clk_in(clk), .resetn_in(rst_n), .instr_word_in(word),
    .instr_valid_in(valid), .branch_taken_in(branch), .guard_timeout_in(guard_to),
    .fetch_ack_out(fetch_ack), .phase_out(ph), .cycle_start_out(cst), .nop_cycle_out(nop),
    .class_out(cls), .file_addr_out(faddr), .dest_file_out(dest), .bit_pos_out(bpos),
    .bit_sel_out(bsel), .lit_out(lit), .lit_wide_out(lwide), .acc_we_out(acc_we),
    .file_we_out(file_we), .guard_clear_out(gclr), .status_flags_out(stat));

  // ==========================================================
  // compare and closing
  task automatic chk(input string name, input logic [10:0] exp, input logic [10:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // load the program, let it run, check each taken word
  task automatic run_prog();
    int          last;
    int          n;
    logic        lastbr;
    logic        br;
    logic        sp;
    logic [13:0] w;
    logic [1:0]  ecls;
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    foreach (prog_q[i]) begin
      load_en  <= 1'b1;
      load_val <= prog_q[i];
      @(posedge clk);
    end
    load_en <= 1'b0;
    go      <= 1'b1;
    last    = -1;
    lastbr  = 1'b0;
    foreach (prog_q[i]) begin
      w  = prog_q[i][13:0];
      sp = (w == SLEEP_WORD) || (w == KICK_WORD);
      br = prog_q[i][14] || (w[13:12] == 2'b10);
      n  = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (fetch_ack !== 1'b1 && n < 40);
      chk("fetch_ack", 11'h1, fetch_ack);
      ecls = (sp || w[13]) ? CL_CTRL : (w[12] ? CL_BIT : CL_BYTE);
      chk("class", ecls, cls);
      chk("nop_cycle", 11'h0, nop);
      chk("phase", 11'h0, ph);
      chk("cycle_start", 11'h1, cst);
      if (last >= 0) chk("spacing", lastbr ? 11'd8 : 11'd4, 11'(cyc - last));
      last   = cyc;
      lastbr = br;
      if (!w[13] && !sp) chk("file_addr", w[6:0], faddr);
      if (!w[13] && !w[12] && !sp) chk("dest", w[7], dest);
      if (w[13:12] == 2'b01) begin
        chk("bit_pos", w[9:7], bpos);
        chk("bit_sel", 8'h01 << w[9:7], bsel);
      end
      if (w[13]) begin
        chk("lit_wide", !w[12], lwide);
        chk("lit", w[12] ? {3'h0, w[7:0]} : w[10:0], lit);
      end
      repeat (2) @(posedge clk);
      #1;
      chk("acc_we", !w[13] && !w[12] && !sp && !w[7], acc_we);
      chk("file_we", !w[13] && !w[12] && !sp && w[7], file_we);
      chk("guard_clear", sp, gclr);
      chk("phase", 11'h2, ph);
      chk("cycle_start", 11'h0, cst);
      if (w == SLEEP_WORD) begin
        @(posedge clk);
        #1;
        chk("status", 11'h010, stat);
      end
      if (br) begin
        repeat (2) @(posedge clk);
        #1;
        chk("nop_cycle", 11'h1, nop);
      end
    end
    go <= 1'b0;
  endtask

  // ==========================================================
  // test sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("status", 11'h018, stat);
    $display("test reset done");
    // extremes of file address, both destinations
    prog_q = '{15'h07ff, 15'h0700, 15'h0500, 15'h0080, 15'h077f};
    run_prog();
    $display("test byte done");
    prog_q.delete();
    for (int b = 0; b < 8; b++) prog_q.push_back(15'h1000 | 15'(b << 7) | 15'h0055);
    run_prog();
    $display("test bit done");
    // wide literal branches on its own; bit 14 asks the datapath for one
    prog_q = '{15'h30a5, 15'h27ff, 15'h3f5a, 15'h2001, 15'h4705, 15'h0123, 15'h50aa, 15'h1080};
    run_prog();
    $display("test control done");
    prog_q = '{15'h0064, 15'h0063, 15'h0064};
    run_prog();
    repeat (2) @(posedge clk);
    #1;
    chk("status", 11'h010, stat);
    @(posedge clk);
    guard_to <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    chk("status", 11'h000, stat);
    @(posedge clk);
    guard_to <= 1'b0;
    prog_q = '{15'h0063};
    run_prog();
    $display("test status done");
    // second reset between runs, with no program running, restores the flags
    prog_q = '{15'h0700, 15'h0080};
    repeat (3) @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("status", 11'h018, stat);
    run_prog();
    $display("test rerun done");
    finish_test();
  end

  // runs take a few hundred cycles; far more means a hang
  initial begin
    #(40ns * 20000);
    failures++;
    $display("[ERR] watchdog expected done seen hang");
    finish_test();
  end
endmodule
`default_nettype wire
